// ==== common/cis_pkg.sv ====
// Purpose: constants and types for the cpu interrupt sequencer
// Assumes: one core clock of 40 MHz, active-low asynchronous reset
// Notes:   vector word addresses are per source index, source 0 lowest address, highest priority
//
// Overview of operation
// RULE1: core clock drives the sequencer directly, no internal divider anywhere.
// RULE2: two-operand alu op reads, computes and writes back in one cycle.
// RULE3: each source has its own vector; taken only with own and global enable.
// RULE4: either boot lock bit may suppress interrupts depending on program counter.
// RULE5: lower vector address wins; reset highest, then external request zero.
// RULE6: relocate select moves vector table to the boot flash start.
// RULE7: reset vector boot fuse fetches reset vector from boot flash start.
// RULE8: accepting an interrupt clears the global enable bit.
// RULE9: software setting global enable inside a handler allows nesting.
// RULE10: vectoring clears the hardware flag of a flag-type source.
// RULE11: writing one to a flag clears it; zero leaves it.
// RULE12: a flag event while disabled still sets and holds the flag.
// RULE13: flags pending during global disable are serviced later by priority.
// RULE14: level sources request only while condition present, never latched.
// RULE15: after return one main-program instruction runs before any interrupt.
// RULE16: handler software saves and restores the status word itself.
// RULE17: global disable acts at once, even against a same-cycle request.
// RULE18: the instruction after global enable runs before any interrupt.
// RULE19: entry takes four cycles pushing the program counter, then the vector.
// RULE20: a request during a multi-cycle instruction waits for its completion.
// RULE21: waking from sleep adds four cycles to entry.
// RULE22: return takes four cycles: pop pc, sp plus two, set global enable.
// RULE23: entry push decrements the stack pointer by two.
package cis_pkg;

    // ==========================================================
    // sizes
    localparam int         NSRC        = 8;
    localparam int         SRC_W       = 3;
    localparam int         PC_W        = 16;
    localparam int         SP_W        = 16;
    localparam logic [7:0] LEVEL_MASK  = 8'hc0;   // sources 6 and 7 are level type

    // ==========================================================
    // vectors and protection
    localparam logic [15:0] VEC_BASE_LOW   = 16'h0000;
    localparam logic [15:0] VEC_STRIDE     = 16'h0002;
    localparam logic [15:0] BOOT_START     = 16'hf000;   // default boot flash start
    localparam logic [15:0] SP_STEP        = 16'h0002;
    localparam logic [15:0] PC_STEP        = 16'h0001;

    // ==========================================================
    // timing
    localparam int         CLK_MHZ       = 40;
    localparam int         ENTRY_CYC     = 4;
    localparam int         WAKE_CYC      = 4;
    localparam int         RET_CYC       = 4;
    localparam logic [3:0] ENTRY_LAST    = 4'(ENTRY_CYC - 1);
    localparam logic [3:0] WAKE_ENTRY_LAST = 4'(ENTRY_CYC + WAKE_CYC - 1);
    localparam logic [3:0] RET_LAST      = 4'(RET_CYC - 1);

    // ==========================================================
    // alu operations
    typedef enum logic [2:0]
    {
        CIS_ADD = 3'b000,
        CIS_SUB = 3'b001,
        CIS_AND = 3'b010,
        CIS_OR  = 3'b011,
        CIS_XOR = 3'b100,
        CIS_MOV = 3'b101
    } cis_alu_op_t;

    typedef enum logic [1:0]
    {
        ST_RUN   = 2'b00,
        ST_ENTRY = 2'b01,
        ST_RET   = 2'b10
    } cis_state_t;

endpackage

// ==== design/cis_flags.sv ====
// Purpose: per-source flag latch and request gating
// Assumes: events are one-cycle pulses on the core clock
// Notes:   set wins over any clear in the same cycle

module cis_flags
    import cis_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic [NSRC-1:0] event_in,
    input  wire logic [NSRC-1:0] level_in,
    input  wire logic [NSRC-1:0] enable,
    input  wire logic [NSRC-1:0] sw_clear,
    input  wire logic [NSRC-1:0] hw_clear,
    output logic      [NSRC-1:0] flag,
    output logic      [NSRC-1:0] request
);

    typedef struct packed
    {
        logic [NSRC-1:0] flag;
    } cis_flag_state_t;

    cis_flag_state_t st;
    cis_flag_state_t next_st;

    // ==========================================================
    // per-source latch
    genvar g;
    generate
        for (g = 0; g < NSRC; g++)
        begin : g_src
            if (LEVEL_MASK[g])
            begin : g_lvl
                // level sources keep no memory of a vanished condition
                assign next_st.flag[g] = 1'b0;
                assign request[g]      = level_in[g] & enable[g];   // RULE14
            end
            else
            begin : g_edge
                assign next_st.flag[g] = event_in[g] |
                                         (st.flag[g] & ~sw_clear[g] & ~hw_clear[g]); // RULE11 RULE12
                assign request[g]      = st.flag[g] & enable[g];    // RULE3
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign flag = st.flag;

endmodule

// ==== design/cis_alu.sv ====
// Purpose: single cycle two-register alu with write back
// Assumes: 32 x 8 register file, write back on the same edge
// Notes:   the file is small, so flops rather than a memory macro

module cis_alu
    import cis_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        go,
    input  cis_alu_op_t      op,
    input  wire logic [4:0]  dst,
    input  wire logic [4:0]  src,
    output logic      [7:0]  result
);

    typedef struct packed
    {
        logic [31:0][7:0] regs;
        logic [7:0]       result;
    } cis_alu_state_t;

    cis_alu_state_t st;
    cis_alu_state_t next_st;
    logic [7:0]     a;
    logic [7:0]     b;
    logic [7:0]     r;

    always_comb
    begin
        next_st = st;
        a       = st.regs[dst];
        b       = st.regs[src];
        unique case (op)
            CIS_ADD: r = a + b;
            CIS_SUB: r = a - b;
            CIS_AND: r = a & b;
            CIS_OR:  r = a | b;
            CIS_XOR: r = a ^ b;
            CIS_MOV: r = b;
            default: r = a;
        endcase
        if (go)
        begin
            next_st.regs[dst] = r;      // RULE2
            next_st.result    = r;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // each register wakes holding its own index, the only preload path
            st.result <= '0;
            for (int i = 0; i < 32; i++)
                st.regs[i] <= 8'(i);
        end
        else
            st <= next_st;
    end

    assign result = st.result;

endmodule

// ==== design/cis_top.sv ====
// Purpose: interrupt acceptance, entry and return sequencing for the core
// Assumes: pipeline reports instruction completion with INSN_DONE
// Notes:   status word save is left to handler software

module cis_top
    import cis_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RSTN,
    input  wire logic [NSRC-1:0]   SRC_EVENT,
    input  wire logic [NSRC-1:0]   SRC_LEVEL,
    input  wire logic [NSRC-1:0]   SRC_ENABLE,
    input  wire logic [NSRC-1:0]   FLAG_WRITE,
    input  wire logic              INSN_DONE,
    input  wire logic              OP_SEI,
    input  wire logic              OP_CLI,
    input  wire logic              OP_RETURN_FROM_IRQ_OP,
    input  wire logic              SLEEPING,
    input  wire logic [PC_W-1:0]   PC_NOW,
    input  wire logic [PC_W-1:0]   POP_PC,
    input  wire logic              VECTOR_RELOCATE_SELECT,
    input  wire logic              RESET_VECTOR_BOOT_FUSE,
    input  wire logic              APP_SECTION_BOOT_LOCK,
    input  wire logic              BOOT_SECTION_BOOT_LOCK,
    input  wire logic [15:0]       BOOT_START_ADDR,
    input  wire logic              ALU_GO,
    input  cis_alu_op_t            ALU_OP,
    input  wire logic [4:0]        ALU_DST,
    input  wire logic [4:0]        ALU_SRC,
    output logic                   GLOBAL_ENABLE,
    output logic [NSRC-1:0]        FLAGS,
    output logic                   STALL,
    output logic                   PUSH_PC,
    output logic                   LOAD_PC,
    output logic [PC_W-1:0]        NEW_PC,
    output logic [SP_W-1:0]        STACK_PTR,
    output logic [PC_W-1:0]        RESET_VECTOR,
    output logic                   IRQ_TAKEN,
    output logic [SRC_W-1:0]       IRQ_SOURCE,
    output logic [7:0]             ALU_RESULT
);

    typedef struct packed
    {
        cis_state_t       state;
        logic             gie;
        logic             hold_one;     // one more instruction before next entry
        logic [3:0]       cnt;
        logic [3:0]       last;
        logic [SRC_W-1:0] src;
        logic             stall;
        logic             push_pc;
        logic             load_pc;
        logic [PC_W-1:0]  new_pc;
        logic [SP_W-1:0]  sp;
        logic [PC_W-1:0]  rst_vec;
        logic             taken;
        logic [NSRC-1:0]  hw_clear;
    } cis_state_s_t;

    cis_state_s_t    st;
    cis_state_s_t    next_st;
    logic [NSRC-1:0] request;
    logic [NSRC-1:0] flag;
    logic [NSRC-1:0] hw_clear_now;
    logic            any_req;
    logic [SRC_W-1:0] win;
    logic            locked;
    logic [15:0]     vec_base;
    logic [15:0]     boot_lo;

    // ==========================================================
    // source flags and gating
    cis_flags u_flags
    (
        .clk      (CLK),
        .rst_n    (RSTN),
        .event_in (SRC_EVENT),
        .level_in (SRC_LEVEL),
        .enable   (SRC_ENABLE),
        .sw_clear (FLAG_WRITE),     // RULE11
        .hw_clear (hw_clear_now),
        .flag     (flag),
        .request  (request)
    );

    // ==========================================================
    // register file and alu
    cis_alu u_alu
    (
        .clk    (CLK),
        .rst_n  (RSTN),
        .go     (ALU_GO),
        .op     (ALU_OP),
        .dst    (ALU_DST),
        .src    (ALU_SRC),
        .result (ALU_RESULT)
    );

    // ==========================================================
    // priority and protection
    always_comb
    begin
        win     = '0;
        any_req = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (request[i])
            begin
                win     = SRC_W'(i);    // RULE5
                any_req = 1'b1;
            end
        end
    end

    // boot lock: suppress while executing outside the section the lock guards
    assign boot_lo = BOOT_START_ADDR;
    assign locked  = (APP_SECTION_BOOT_LOCK  & (PC_NOW >= boot_lo)) |
                     (BOOT_SECTION_BOOT_LOCK & (PC_NOW <  boot_lo));   // RULE4
    assign vec_base = VECTOR_RELOCATE_SELECT ? boot_lo : VEC_BASE_LOW; // RULE6
    assign hw_clear_now = st.hw_clear;

    // ==========================================================
    // sequencer
    always_comb
    begin
        next_st          = st;
        next_st.push_pc  = 1'b0;
        next_st.load_pc  = 1'b0;
        next_st.taken    = 1'b0;
        next_st.hw_clear = '0;
        next_st.rst_vec  = RESET_VECTOR_BOOT_FUSE ? boot_lo : VEC_BASE_LOW;  // RULE7
        if (OP_SEI)
            next_st.gie = 1'b1;         // RULE9
        if (OP_CLI)
            next_st.gie = 1'b0;
        unique case (st.state)
            ST_RUN:
            begin
                next_st.stall = 1'b0;
                if (INSN_DONE && !OP_SEI)
                    next_st.hold_one = 1'b0;    // RULE15 RULE18
                if (OP_SEI)
                    next_st.hold_one = 1'b1;    // RULE18
                if (OP_RETURN_FROM_IRQ_OP)
                begin
                    next_st.state = ST_RET;
                    next_st.cnt   = '0;
                    next_st.stall = 1'b1;
                end
                // cli in this cycle wins; gated by current gie and done
                else if (st.gie && !OP_CLI && !st.hold_one && INSN_DONE &&
                         any_req && !locked)    // RULE3 RULE13 RULE17 RULE20
                begin
                    next_st.state   = ST_ENTRY;
                    next_st.src     = win;
                    next_st.gie     = 1'b0;     // RULE8
                    next_st.cnt     = '0;
                    next_st.last    = SLEEPING ? WAKE_ENTRY_LAST : ENTRY_LAST; // RULE21
                    next_st.stall   = 1'b1;
                    next_st.taken   = 1'b1;
                    next_st.push_pc = 1'b1;
                    next_st.sp      = st.sp - SP_STEP;   // RULE23
                    next_st.hw_clear = NSRC'(1) << win;  // RULE10
                end
            end
            ST_ENTRY:
            begin
                next_st.cnt = st.cnt + 4'h1;
                if (st.cnt == st.last)                   // RULE19
                begin
                    next_st.state   = ST_RUN;
                    next_st.stall   = 1'b0;
                    next_st.load_pc = 1'b1;
                    next_st.new_pc  = vec_base + VEC_STRIDE +
                                      16'(st.src) * VEC_STRIDE;
                end
            end
            ST_RET:
            begin
                next_st.cnt = st.cnt + 4'h1;
                if (st.cnt == RET_LAST)                  // RULE22
                begin
                    next_st.state    = ST_RUN;
                    next_st.stall    = 1'b0;
                    next_st.load_pc  = 1'b1;
                    next_st.new_pc   = POP_PC + PC_STEP;
                    next_st.sp       = st.sp + SP_STEP;
                    next_st.gie      = 1'b1;
                    next_st.hold_one = 1'b1;             // RULE15
                end
            end
            default:
                next_st.state = ST_RUN;
        endcase
    end

    // single clock straight from the pin, no divider in the path
    always_ff @(posedge CLK or negedge RSTN)   // RULE1
    begin
        if (!RSTN)
            st <= '0;
        else
            st <= next_st;
    end

    // ==========================================================
    // outputs
    assign GLOBAL_ENABLE = st.gie;
    assign FLAGS         = flag;
    assign STALL         = st.stall;
    assign PUSH_PC       = st.push_pc;
    assign LOAD_PC       = st.load_pc;
    assign NEW_PC        = st.new_pc;
    assign STACK_PTR     = st.sp;
    assign RESET_VECTOR  = st.rst_vec;
    assign IRQ_TAKEN     = st.taken;
    assign IRQ_SOURCE    = st.src;

endmodule

// ==== bench/cis_top_sva.sv ====
// Purpose: port-level timing checks for the interrupt sequencer
// Assumes: single core clock, asynchronous active-low reset
// Notes:   entry and return bounds allow one cycle of slack
module cis_top_sva
    import cis_pkg::*;
(
    input wire logic             CLK,
    input wire logic             RSTN,
    input wire logic             IRQ_TAKEN,
    input wire logic [SRC_W-1:0] IRQ_SOURCE,
    input wire logic             LOAD_PC,
    input wire logic             PUSH_PC,
    input wire logic             STALL,
    input wire logic [SP_W-1:0]  STACK_PTR,
    input wire logic             GLOBAL_ENABLE,
    input wire logic [NSRC-1:0]  FLAGS,
    input wire logic [NSRC-1:0]  SRC_ENABLE,
    input wire logic             INSN_DONE,
    input wire logic             OP_SEI,
    input wire logic             OP_CLI,
    input wire logic             OP_RETURN_FROM_IRQ_OP,
    input wire logic             SLEEPING
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // sequences
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    sequence s_entry;
        PUSH_PC && STALL ##1 !LOAD_PC [*2] ##[1:2] LOAD_PC;
    endsequence
    sequence s_wake;
        PUSH_PC && STALL ##1 !LOAD_PC [*6] ##[1:2] LOAD_PC;
    endsequence
    sequence s_ret;
        OP_RETURN_FROM_IRQ_OP ##1 !LOAD_PC [*3] ##[1:2] LOAD_PC;
    endsequence
    // ==========================================================
    // properties
    property p_entry;
        IRQ_TAKEN && !$past(SLEEPING) |-> s_entry;
    endproperty
    a_entry: assert property (p_entry) else $error("entry timing");
    property p_wake;
        IRQ_TAKEN && $past(SLEEPING) |-> s_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("wake entry timing");
    property p_ret;
        OP_RETURN_FROM_IRQ_OP |-> s_ret ##1 (GLOBAL_ENABLE && !IRQ_TAKEN);
    endproperty
    a_ret: assert property (p_ret) else $error("return timing");
    property p_gate;
        IRQ_TAKEN |-> $past(GLOBAL_ENABLE) && $past(INSN_DONE) && !GLOBAL_ENABLE;
    endproperty
    a_gate: assert property (p_gate) else $error("take gating");
    property p_sp;
        IRQ_TAKEN |-> STACK_PTR == $past(STACK_PTR) - SP_STEP;
    endproperty
    a_sp: assert property (p_sp) else $error("stack pointer on entry");
    property p_prio;
        IRQ_TAKEN |-> ($past(FLAGS) & $past(SRC_ENABLE)
            & ((8'h01 << IRQ_SOURCE) - 8'h01)) == 8'h00;
    endproperty
    a_prio: assert property (p_prio) else $error("priority order");
    property p_hwclr;
        IRQ_TAKEN && !LEVEL_MASK[IRQ_SOURCE] |-> ##[0:1] !FLAGS[IRQ_SOURCE];
    endproperty
    a_hwclr: assert property (p_hwclr) else $error("flag not cleared");
    property p_cli;
        OP_CLI |=> !IRQ_TAKEN && !GLOBAL_ENABLE;
    endproperty
    a_cli: assert property (p_cli) else $error("take after disable");
    property p_sei;
        OP_SEI |=> !IRQ_TAKEN [*2];
    endproperty
    a_sei: assert property (p_sei) else $error("take too soon after enable");
    property p_lvl;
        (FLAGS & LEVEL_MASK) == 8'h00;
    endproperty
    a_lvl: assert property (p_lvl) else $error("level source latched");
endmodule

bind cis_top cis_top_sva cis_top_sva_inst (.CLK, .RSTN, .IRQ_TAKEN, .IRQ_SOURCE, .LOAD_PC,
    .PUSH_PC, .STALL, .STACK_PTR, .GLOBAL_ENABLE, .FLAGS, .SRC_ENABLE, .INSN_DONE,
    .OP_SEI, .OP_CLI, .OP_RETURN_FROM_IRQ_OP, .SLEEPING);

// ==== bench/cis_core_model.sv ====
// Purpose: pipeline and stack memory facing the sequencer
// Assumes: multi-cycle ops last three cycles
// Notes:   stack holds four return addresses, enough for the nesting used
module cis_core_model
    import cis_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            multi,
    input  wire logic            stall,
    input  wire logic            push_pc,
    input  wire logic            load_pc,
    input  wire logic            op_return_from_irq_op,
    input  wire logic [PC_W-1:0] pc_now,
    output logic                 insn_done,
    output logic      [PC_W-1:0] pop_pc
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [PC_W-1:0] stk [4];
    logic [1:0]      dp;
    logic [1:0]      cnt;
    logic            ret_busy;
    // ==========================================================
    // pipeline
    // a multi-cycle op reports completion only in its last cycle
    assign insn_done = !stall && (!multi || cnt == 2'h2);
    // empty stack shows a changing pattern, never a stale address
    assign pop_pc = (dp != 2'h0) ? stk[dp - 2'h1] : {8{cnt}};
    // status word is never saved here; that stays with handler code
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt      <= 2'h0;
            dp       <= 2'h0;
            ret_busy <= 1'b0;
        end
        else
        begin
            cnt <= (stall || cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
            if (op_return_from_irq_op)
                ret_busy <= 1'b1;
            if (push_pc)
            begin
                stk[dp] <= pc_now;
                dp      <= dp + 2'h1;
            end
            else if (load_pc && ret_busy)
            begin
                dp       <= dp - 2'h1;
                ret_busy <= 1'b0;
            end
        end
    end
endmodule

// ==== bench/cis_top_tb.sv ====
// Purpose: self-checking bench for the interrupt sequencer
// Assumes: inputs change on the falling edge of a 40 MHz clock
// Notes:   alu runs on the register contents left by reset
module cis_top_tb;
    import cis_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic             clk = 1'b0;
    logic             rst_n, insn_done, op_sei, op_cli, op_return_from_irq_op, sleeping, multi;
    logic             relocate, boot_fuse, app_lock, boot_lock;
    logic             gie, stall, push_pc, load_pc, irq_taken;
    logic [NSRC-1:0]  src_event, src_level, src_enable, flag_write, flags;
    logic [15:0]      pc_now, pop_pc, boot_start, new_pc, stack_ptr, reset_vector;
    logic [SRC_W-1:0] irq_source;
    logic [7:0]       alu_result;
    logic             alu_go;
    logic [4:0]       alu_dst, alu_src;
    cis_alu_op_t      alu_op;
    int               err_count = 0;
    int               compares = 0;
    always #12.5 clk = ~clk;
    cis_top cis_top_inst (.CLK(clk), .RSTN(rst_n), .SRC_EVENT(src_event),
        .SRC_LEVEL(src_level), .SRC_ENABLE(src_enable), .FLAG_WRITE(flag_write),
        .INSN_DONE(insn_done), .OP_SEI(op_sei), .OP_CLI(op_cli), .OP_RETURN_FROM_IRQ_OP(op_return_from_irq_op),
        .SLEEPING(sleeping), .PC_NOW(pc_now), .POP_PC(pop_pc),
        .VECTOR_RELOCATE_SELECT(relocate), .RESET_VECTOR_BOOT_FUSE(boot_fuse),
        .APP_SECTION_BOOT_LOCK(app_lock), .BOOT_SECTION_BOOT_LOCK(boot_lock),
        .BOOT_START_ADDR(boot_start), .ALU_GO(alu_go), .ALU_OP(alu_op),
        .ALU_DST(alu_dst), .ALU_SRC(alu_src), .GLOBAL_ENABLE(gie), .FLAGS(flags),
        .STALL(stall), .PUSH_PC(push_pc), .LOAD_PC(load_pc), .NEW_PC(new_pc),
        .STACK_PTR(stack_ptr), .RESET_VECTOR(reset_vector), .IRQ_TAKEN(irq_taken),
        .IRQ_SOURCE(irq_source), .ALU_RESULT(alu_result));
    cis_core_model cis_core_model_inst (.clk(clk), .rst_n(rst_n), .multi(multi),
        .stall(stall), .push_pc(push_pc), .load_pc(load_pc), .op_return_from_irq_op(op_return_from_irq_op),
        .pc_now(pc_now), .insn_done(insn_done), .pop_pc(pop_pc));
    // ==========================================================
    // helpers
    task automatic test_done();
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic tick(inout int n);
        cyc(1);
        n++;
        if (n > 40)
        begin
            err_count++;
            test_done();
        end
    endtask
    task automatic wait_load(input int lo);
        int n;
        n = 0;
        while (load_pc !== 1'b1)
            tick(n);
        chk(16'(n >= lo && n <= lo + 1), 16'h0001);
    endtask
    task automatic take(input logic [2:0] src, input logic [15:0] vec, input int lo);
        int n;
        n = 0;
        while (irq_taken !== 1'b1)
            tick(n);
        sleeping = 1'b0;
        chk(16'(irq_source), 16'(src));
        wait_load(lo);
        chk(new_pc, vec);
    endtask
    task automatic return_from_irq_op(input logic [15:0] sp, input logic [15:0] pc);
        op_return_from_irq_op = 1'b1;
        cyc(1);
        op_return_from_irq_op = 1'b0;
        wait_load(3);
        chk(new_pc, pc);
        cyc(1);
        chk(stack_ptr, sp);
        chk(16'(gie), 16'h0001);
    endtask
    task automatic alu(input cis_alu_op_t op, input logic [4:0] d, input logic [4:0] s,
                       input logic [7:0] exp);
        alu_go  = 1'b1;
        alu_op  = op;
        alu_dst = d;
        alu_src = s;
        cyc(1);
        chk(16'(alu_result), 16'(exp));
    endtask
    task automatic sei();
        op_sei = 1'b1;
        cyc(1);
        op_sei = 1'b0;
    endtask
    task automatic pulse(input logic [7:0] ev);
        src_event = ev;
        cyc(1);
        src_event = 8'h00;
    endtask
    task automatic do_reset(input logic fuse);
        rst_n = 1'b0;
        boot_fuse = fuse;
        cyc(5);
        rst_n = 1'b1;
        cyc(2);
        chk(reset_vector, fuse ? boot_start : 16'h0000);
        chk(stack_ptr, 16'h0000);
        chk(16'(gie), 16'h0000);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_alu();
        alu(CIS_ADD, 5'h01, 5'h02, 8'h03);
        alu(CIS_XOR, 5'h01, 5'h04, 8'h07);
        alu(CIS_SUB, 5'h1f, 5'h01, 8'h18);
        alu(CIS_AND, 5'h1f, 5'h0c, 8'h08);
        alu(CIS_OR, 5'h05, 5'h1f, 8'h0d);
        alu(CIS_MOV, 5'h00, 5'h05, 8'h0d);
        alu_go = 1'b0;
    endtask
    task automatic t_pending();
        pulse(8'h0a);
        cyc(2);
        chk(16'(flags), 16'h000a);
        src_enable = 8'h0a;
        cyc(4);
        chk(16'(flags), 16'h000a);
        sei();
        take(3'h1, 16'h0004, 3);
        chk(stack_ptr, 16'hfffe);
        chk(16'(flags), 16'h0008);
        chk(16'(gie), 16'h0000);
        sei();
        take(3'h3, 16'h0008, 3);
        chk(stack_ptr, 16'hfffc);
        pulse(8'h08);
        return_from_irq_op(16'hfffe, 16'h0101);
        take(3'h3, 16'h0008, 3);
        return_from_irq_op(16'hfffe, 16'h0101);
        return_from_irq_op(16'h0000, 16'h0101);
        src_enable = 8'h00;
    endtask
    task automatic t_clear_cli();
        pulse(8'h14);
        flag_write = 8'h10;
        cyc(1);
        flag_write = 8'h00;
        chk(16'(flags), 16'h0004);
        flag_write = 8'h04;
        cyc(1);
        flag_write = 8'h00;
        pulse(8'h01);
        op_cli = 1'b1;
        src_enable = 8'h01;
        cyc(1);
        op_cli = 1'b0;
        cyc(4);
        chk({7'h00, gie, flags}, 16'h0001);
        flag_write = 8'h01;
        cyc(1);
        flag_write = 8'h00;
        src_enable = 8'h00;
    endtask
    task automatic t_level();
        src_level = 8'h40;
        cyc(2);
        src_level = 8'h00;
        src_enable = 8'h40;
        sei();
        cyc(6);
        chk(16'(gie), 16'h0001);
        multi = 1'b1;
        src_level = 8'h40;
        take(3'h6, 16'h000e, 3);
        src_level = 8'h00;
        multi = 1'b0;
        return_from_irq_op(16'h0000, 16'h0101);
        src_enable = 8'h04;
        relocate = 1'b1;
        sleeping = 1'b1;
        pulse(8'h04);
        take(3'h2, 16'hf006, 7);
        relocate = 1'b0;
        return_from_irq_op(16'h0000, 16'h0101);
    endtask
    task automatic t_lock();
        src_enable = 8'h20;
        app_lock = 1'b1;
        pc_now = 16'hf010;
        pulse(8'h20);
        cyc(8);
        chk(16'(gie), 16'h0001);
        app_lock = 1'b0;
        boot_lock = 1'b1;
        take(3'h5, 16'h000c, 3);
        return_from_irq_op(16'h0000, 16'hf011);
        pc_now = 16'h0100;
        pulse(8'h20);
        cyc(8);
        chk(16'(gie), 16'h0001);
        boot_lock = 1'b0;
        take(3'h5, 16'h000c, 3);
        return_from_irq_op(16'h0000, 16'h0101);
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        {rst_n, op_sei, op_cli, op_return_from_irq_op, sleeping, multi} = 6'h00;
        {relocate, boot_fuse, app_lock, boot_lock} = 4'h0;
        {src_event, src_level, src_enable, flag_write} = 32'h0000_0000;
        pc_now = 16'h0100;
        boot_start = 16'hf000;
        {alu_go, alu_dst, alu_src} = 11'h000;
        alu_op = CIS_ADD;
        do_reset(1'b0);
        t_alu();
        t_pending();
        t_clear_cli();
        t_level();
        t_lock();
        do_reset(1'b1);
        test_done();
    end
endmodule
